// ===== design/arl_top.sv
// Alarm-to-relay logic: setpoint alarms with delays, relay allocation,
// latching and acknowledge, annunciators, analog retransmission, AXI4-Lite.
// Assumes display_value comes from logic on mclk; buttons arrive from pins.
`timescale 1ns/1ns
// Operation
// - Relay driven only by allocated alarms
// - PI control fixes alarm1/relay1, alarm2/relay2
// - Automatic mode releases when condition clears
// - Latch holds until clear and acknowledged
// - Hysteresis and delays apply when latching
// - Latched flash, longer off once cleared
// - Acknowledge makes annunciator steady lit
// - Acknowledged latch releases when condition clears
// - Per-relay polarity, normally open default
// - Acknowledge from button, aux, or remote
// - Early acknowledge retained, auto release later
// - OR mode: any allocated alarm activates
// - AND mode: all allocated alarms needed
// - Range fixed 4-20mA on 12-bit variant
// - Linear scaling low/high display to range
// - High alarm at >=, low at <=
// - Trip delay restarts on any interruption
module arl_top #(
  parameter int NA       = 8,
  parameter int NR       = 8,
  parameter int OUT_BITS = 16,
  parameter int TICK_CYC = arl_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst,
  // AXI4-Lite slave
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // Measured value and operator pins
  input  wire logic [15:0]   display_value,
  input  wire logic          ack_btn,
  input  wire logic          aux_btn,
  input  wire logic          remote_in,
  // Outputs
  output logic [NR-1:0]      relay_coil,
  output logic [NR-1:0]      annunciator_led,
  output logic               irq,
  output logic [15:0]        aout_code,
  output logic [1:0]         analog_range_select
);
  localparam logic [15:0] AMAX = 16'((32'h0000_0001 << OUT_BITS) - 1);

  typedef struct packed {
    logic [2:0]             sy0;
    logic [2:0]             sy1;
    logic [2:0]             sy2;
    logic                   ack_ev;
    logic [31:0]            tick_cnt;
    logic                   tick;
    logic [3:0]             phase;
    logic [7:0]             ctrl;
    logic [NR-1:0][3:0]     rcfg;
    logic [NA-1:0][NR-1:0]  alloc;
    logic [NA-1:0][15:0]    sp_hi;
    logic [NA-1:0][15:0]    sp_lo;
    logic [NA-1:0][15:0]    hys;
    logic [NA-1:0][1:0]     en;
    logic [NA-1:0][15:0]    trip;
    logic [NA-1:0][15:0]    rdly;
    logic [NA-1:0]          alm;
    logic [NA-1:0][15:0]    tmr;
    logic [NR-1:0]          act;
    logic [NR-1:0]          ackd;
    logic [NR-1:0]          coil;
    logic [NR-1:0]          led;
    logic [NR-1:0]          ist;
    logic [NR-1:0]          imsk;
    logic                   irq;
    logic [15:0]            alo;
    logic [15:0]            ahi;
    logic [15:0]            aout;
    logic [1:0]             rng;
    logic                   awready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } arl_state_s;

  arl_state_s s;
  arl_state_s next_s;
  logic [NR-1:0]         comb;
  logic [NR-1:0]         hit;
  logic [NA-1:0][NR-1:0] aeff;

  // Byte-lane merge for partial writes
  function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] w,
                                      input logic [3:0] b);
    logic [31:0] r;
    r = o;
    for (int k = 0; k < 4; k++) begin
      if (b[k]) r[8*k +: 8] = w[8*k +: 8];
    end
    return r;
  endfunction : mrg

  // Whole block next state
  always_comb begin
    logic [2:0]  ackp, wi, ri;
    logic        hi_c, lo_c, raw, all_on, any_on, ackn, ok;
    logic [31:0] m, prod;
    logic [15:0] den;
    ackp = '0;
    hi_c = 1'b0;
    lo_c = 1'b0;
    raw = 1'b0;
    all_on = 1'b0;
    any_on = 1'b0;
    ackn = 1'b0;
    wi = s_axi_awaddr[4:2];
    ri = s_axi_araddr[4:2];
    m = '0;
    ok = 1'b0;
    prod = '0;
    den = '0;
    next_s = s;
    comb = '0;
    hit = '0;

    // Pins through two flops, then rising-edge detect
    next_s.sy0 = {remote_in, aux_btn, ack_btn};
    next_s.sy1 = s.sy0;
    next_s.sy2 = s.sy1;
    ackp = s.sy1 & ~s.sy2;
    next_s.ack_ev = ackp[0] | (ackp[1] & s.ctrl[arl_pkg::C_AUXACK])
                  | (ackp[2] & s.ctrl[arl_pkg::C_REMACK]);

    // Tenth-second tick and flash phase
    next_s.tick = (s.tick_cnt == 32'(TICK_CYC - 1));
    next_s.tick_cnt = next_s.tick ? 32'h0000_0000 : s.tick_cnt + 32'h0000_0001;
    if (s.tick) begin
      next_s.phase = (s.phase == arl_pkg::FL_PER - 4'h1) ? 4'h0 : s.phase + 4'h1;
    end

    // Alarm detect; hysteresis widens only the release edge
    for (int a = 0; a < NA; a++) begin
      hi_c = s.en[a][arl_pkg::EN_HI] &&
             ({1'b0, display_value} + (s.alm[a] ? {1'b0, s.hys[a]} : 17'h0_0000)
              >= {1'b0, s.sp_hi[a]});
      lo_c = s.en[a][arl_pkg::EN_LO] &&
             ({1'b0, display_value}
              <= {1'b0, s.sp_lo[a]} + (s.alm[a] ? {1'b0, s.hys[a]} : 17'h0_0000));
      raw = hi_c | lo_c;
      // Any break in the pending change restarts the delay
      if (raw == s.alm[a]) begin
        next_s.tmr[a] = '0;
      end else if (s.tmr[a] >= (s.alm[a] ? s.rdly[a] : s.trip[a])) begin
        next_s.alm[a] = raw;
        next_s.tmr[a] = '0;
      end else if (s.tick && s.tmr[a] != 16'hFFFF) begin
        next_s.tmr[a] = s.tmr[a] + 16'h0001;
      end
    end

    // Effective allocation
    aeff = s.alloc;
    if (s.ctrl[arl_pkg::C_PI]) begin
      aeff[0] = NR'(1);
      if (NA > 1) aeff[1] = NR'(2);
    end

    // Relay combine, latch and annunciator
    for (int r = 0; r < NR; r++) begin
      any_on = 1'b0;
      all_on = 1'b1;
      for (int a = 0; a < NA; a++) begin
        if (aeff[a][r]) begin
          any_on = any_on | s.alm[a];
          all_on = all_on & s.alm[a];
        end
      end
      // AND needs at least one allocated alarm, or an empty relay trips
      hit[r] = any_on;
      comb[r] = s.rcfg[r][arl_pkg::RC_AND] ? (all_on & any_on) : any_on;
      if (!s.rcfg[r][arl_pkg::RC_LATCH]) begin
        next_s.act[r] = comb[r];
        next_s.ackd[r] = 1'b0;
      end else begin
        ackn = s.ackd[r] | (s.ack_ev & s.act[r]
             & (!comb[r] | s.rcfg[r][arl_pkg::RC_EARLY]));
        if (!s.act[r]) begin
          next_s.act[r] = comb[r];
          next_s.ackd[r] = 1'b0;
        end else if (!comb[r] && ackn) begin
          next_s.act[r] = 1'b0;
          next_s.ackd[r] = 1'b0;
        end else begin
          next_s.ackd[r] = ackn;
        end
      end
      if (!s.rcfg[r][arl_pkg::RC_LATCH] || next_s.ackd[r]) begin
        next_s.led[r] = next_s.act[r];
      end else begin
        next_s.led[r] = next_s.act[r] && (s.phase < (comb[r] ? arl_pkg::FL_FAST
                                                               : arl_pkg::FL_SLOW));
      end
      next_s.coil[r] = next_s.act[r] ^ s.rcfg[r][arl_pkg::RC_NC];
    end

    // Analog retransmission scaling
    next_s.rng = (OUT_BITS == 12 || s.ctrl[arl_pkg::C_RNG +: 2] == 2'b11)
               ? arl_pkg::R_4_20 : s.ctrl[arl_pkg::C_RNG +: 2];
    den = s.ahi - s.alo;
    prod = 32'(display_value - s.alo) * 32'(AMAX);
    if (s.ahi <= s.alo || display_value <= s.alo) next_s.aout = '0;
    else if (display_value >= s.ahi) next_s.aout = AMAX;
    else next_s.aout = 16'(prod / 32'(den));

    // Write channel: take address and data together, answer next cycle
    next_s.awready = 1'b0;
    if (s.bvalid && s_axi_bready) next_s.bvalid = 1'b0;
    if (!s.awready && !s.bvalid && s_axi_awvalid && s_axi_wvalid) next_s.awready = 1'b1;
    if (s.awready) begin
      ok = 1'b1;
      case (s_axi_awaddr[7:5])
        3'h0: begin
          case ({s_axi_awaddr[7:2], 2'b00})
            arl_pkg::A_CTRL: next_s.ctrl = 8'(mrg(32'(s.ctrl), s_axi_wdata, s_axi_wstrb));
            arl_pkg::A_IMSK: next_s.imsk = NR'(mrg(32'(s.imsk), s_axi_wdata, s_axi_wstrb));
            arl_pkg::A_ALO:  next_s.alo = 16'(mrg(32'(s.alo), s_axi_wdata, s_axi_wstrb));
            arl_pkg::A_AHI:  next_s.ahi = 16'(mrg(32'(s.ahi), s_axi_wdata, s_axi_wstrb));
            arl_pkg::A_STAT, arl_pkg::A_IST: ok = 1'b1;
            default: ok = 1'b0;
          endcase
        end
        arl_pkg::G_RCFG: begin
          if (32'(wi) < NR) next_s.rcfg[wi] = 4'(mrg(32'(s.rcfg[wi]), s_axi_wdata, s_axi_wstrb));
          else ok = 1'b0;
        end
        arl_pkg::G_ALOC, arl_pkg::G_SP, arl_pkg::G_HYS, arl_pkg::G_TIM: begin
          if (32'(wi) >= NA) ok = 1'b0;
          else if (s_axi_awaddr[7:5] == arl_pkg::G_ALOC)
            next_s.alloc[wi] = NR'(mrg(32'(s.alloc[wi]), s_axi_wdata, s_axi_wstrb));
          else if (s_axi_awaddr[7:5] == arl_pkg::G_SP) begin
            m = mrg({s.sp_hi[wi], s.sp_lo[wi]}, s_axi_wdata, s_axi_wstrb);
            next_s.sp_hi[wi] = m[31:16];
            next_s.sp_lo[wi] = m[15:0];
          end else if (s_axi_awaddr[7:5] == arl_pkg::G_HYS) begin
            m = mrg({s.hys[wi], 14'h0000, s.en[wi]}, s_axi_wdata, s_axi_wstrb);
            next_s.hys[wi] = m[31:16];
            next_s.en[wi] = m[1:0];
          end else begin
            m = mrg({s.rdly[wi], s.trip[wi]}, s_axi_wdata, s_axi_wstrb);
            next_s.rdly[wi] = m[31:16];
            next_s.trip[wi] = m[15:0];
          end
        end
        default: ok = 1'b0;
      endcase
      next_s.bvalid = 1'b1;
      next_s.bresp = ok ? arl_pkg::RESP_OK : arl_pkg::RESP_ERR;
    end

    // Read channel; an interrupt status read clears the events it returned
    ok = 1'b0;
    m = '0;
    next_s.arready = 1'b0;
    if (s.rvalid && s_axi_rready) next_s.rvalid = 1'b0;
    if (!s.arready && !s.rvalid && s_axi_arvalid) next_s.arready = 1'b1;
    next_s.ist = s.ist;
    if (s.arready) begin
      ok = 1'b1;
      case (s_axi_araddr[7:5])
        3'h0: begin
          case ({s_axi_araddr[7:2], 2'b00})
            arl_pkg::A_CTRL: m = 32'(s.ctrl);
            arl_pkg::A_STAT: m = 32'(s.act) | (32'(s.coil) << 8) | (32'(s.alm) << 16);
            arl_pkg::A_IST: begin
              m = 32'(s.ist);
              next_s.ist = '0;
            end
            arl_pkg::A_IMSK: m = 32'(s.imsk);
            arl_pkg::A_ALO:  m = 32'(s.alo);
            arl_pkg::A_AHI:  m = 32'(s.ahi);
            default: ok = 1'b0;
          endcase
        end
        arl_pkg::G_RCFG: if (32'(ri) < NR) m = 32'(s.rcfg[ri]); else ok = 1'b0;
        arl_pkg::G_ALOC: if (32'(ri) < NA) m = 32'(s.alloc[ri]); else ok = 1'b0;
        arl_pkg::G_SP:   if (32'(ri) < NA) m = {s.sp_hi[ri], s.sp_lo[ri]}; else ok = 1'b0;
        arl_pkg::G_HYS:  if (32'(ri) < NA) m = {s.hys[ri], 14'h0000, s.en[ri]}; else ok = 1'b0;
        arl_pkg::G_TIM:  if (32'(ri) < NA) m = {s.rdly[ri], s.trip[ri]}; else ok = 1'b0;
        default: ok = 1'b0;
      endcase
      next_s.rvalid = 1'b1;
      next_s.rdata = m;
      next_s.rresp = ok ? arl_pkg::RESP_OK : arl_pkg::RESP_ERR;
    end

    // Activation events: set beats a same-cycle read clear
    next_s.ist = next_s.ist | (next_s.act & ~s.act);
    next_s.irq = |(next_s.ist & s.imsk);
  end

  // State register; latches also clear here, as on power loss
  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
      s.ahi <= arl_pkg::AHI_RST;
      s.alo <= arl_pkg::ALO_RST;
      s.hys <= {NA{arl_pkg::HYS_RST}};
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state flops
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.awready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign relay_coil = s.coil;
  assign annunciator_led = s.led;
  assign irq = s.irq;
  assign aout_code = s.aout;
  assign analog_range_select = s.rng;

  // Checks on relay 0, alarm 0, the acknowledge pulse and the analog range
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_ack_clear;
    s.rcfg[0][arl_pkg::RC_LATCH] && s.act[0] && !comb[0] && s.ack_ev;
  endsequence
  sequence s_latch_wait;
    s.rcfg[0][arl_pkg::RC_LATCH] && s.act[0] && !s.ackd[0] && !s.ack_ev;
  endsequence

  AST_ALLOC: assert property (!s.rcfg[0][arl_pkg::RC_LATCH] && !hit[0] |=> !s.act[0])
    else $error("relay driven without allocation");
  AST_PI: assert property (s.ctrl[arl_pkg::C_PI] |-> aeff[0] == NR'(1))
    else $error("pi allocation not fixed");
  AST_AUTO: assert property (!s.rcfg[0][arl_pkg::RC_LATCH] && !comb[0] |=> !s.act[0])
    else $error("auto relay not released");
  AST_HOLD: assert property (s_latch_wait |=> s.act[0])
    else $error("latched relay dropped early");
  AST_ACKREL: assert property (s_ack_clear |=> !s.act[0])
    else $error("acknowledged latch not released");
  AST_SOLID: assert property (s.rcfg[0][arl_pkg::RC_LATCH] && s.act[0] && s.ackd[0]
    && $stable(s.rcfg[0]) |=> s.led[0] || !s.act[0])
    else $error("acknowledged annunciator not steady");
  AST_POL: assert property (##1 s.coil[0] == (s.act[0] ^ $past(s.rcfg[0][arl_pkg::RC_NC])))
    else $error("coil polarity wrong");
  AST_ONEACK: assert property (s.ack_ev |=> !s.ack_ev)
    else $error("acknowledge longer than one cycle");
  AST_TRIP: assert property (!s.alm[0] && s.tmr[0] < s.trip[0] |=> !s.alm[0])
    else $error("alarm tripped before delay");
  AST_RNG: assert property (OUT_BITS == 12 || s.ctrl[arl_pkg::C_RNG +: 2] == 2'b11
    |=> s.rng == arl_pkg::R_4_20)
    else $error("range not fixed on 12-bit variant");
  AST_IRQ: assert property (s.act[0] && !$past(s.act[0]) && s.imsk[0] |-> ##1 s.irq)
    else $error("activation did not raise interrupt");
endmodule : arl_top

// ===== inc/arl_pkg.sv
// Constants for the alarm-to-relay block: register map, fields, resets, timing.
// Assumes a 20 MHz mclk and an AXI4-Lite master with an 8-bit byte address.
package arl_pkg;
  // Register byte addresses and word groups (addr[7:5])
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_IST  = 8'h08;
  localparam logic [7:0] A_IMSK = 8'h0C;
  localparam logic [7:0] A_ALO  = 8'h10;
  localparam logic [7:0] A_AHI  = 8'h14;
  localparam logic [2:0] G_RCFG = 3'h2;
  localparam logic [2:0] G_ALOC = 3'h4;
  localparam logic [2:0] G_SP   = 3'h5;
  localparam logic [2:0] G_HYS  = 3'h6;
  localparam logic [2:0] G_TIM  = 3'h7;
  // Control fields
  localparam int C_PI     = 0;
  localparam int C_AUXACK = 1;
  localparam int C_REMACK = 2;
  localparam int C_RNG    = 4;
  // Per-relay config fields
  localparam int RC_LATCH = 0;
  localparam int RC_AND   = 1;
  localparam int RC_NC    = 2;
  localparam int RC_EARLY = 3;
  // Per-alarm enable fields
  localparam int EN_HI = 0;
  localparam int EN_LO = 1;
  // Reset values
  localparam logic [15:0] ALO_RST = 16'h0000;
  localparam logic [15:0] AHI_RST = 16'h03E8;
  localparam logic [15:0] HYS_RST = 16'h000A;
  // Analog output ranges
  typedef enum logic [1:0] {
    R_4_20  = 2'b00,
    R_0_1V  = 2'b01,
    R_0_10V = 2'b10
  } arl_range_e;
  // Timing: delays count in 0.1 s ticks
  localparam int CLK_NS   = 50;
  localparam int TICK_NS  = 100_000_000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam logic [3:0] FL_PER  = 4'hA;
  localparam logic [3:0] FL_FAST = 4'h5;
  localparam logic [3:0] FL_SLOW = 4'h2;
  // Bus answers
  localparam logic [1:0] RESP_OK  = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;
endpackage : arl_pkg

// ===== tb/arl_panel_model.sv
// Operator panel model: the ack, aux and remote buttons seen from the pins.
// Assumes the bench asks for a press with a one-cycle request bit.
`timescale 1ns/1ns
module arl_panel_model #(
  parameter int HOLD = 6
) (
  // Clock
  input  wire logic       mclk,
  // Press requests, bit 0 ack, bit 1 aux, bit 2 remote
  input  wire logic [2:0] press,
  // Button pins towards the block
  output logic      [2:0] pins
);
  int cnt [3] = '{0, 0, 0};
  // A press holds its pin several cycles, as a human finger would
  always @(posedge mclk) begin
    for (int i = 0; i < 3; i++) begin
      if (press[i] === 1'b1)
        cnt[i] <= HOLD;
      else if (cnt[i] > 0)
        cnt[i] <= cnt[i] - 1;
    end
  end
  // Released buttons read low
  assign pins = {cnt[2] != 0, cnt[1] != 0, cnt[0] != 0};
endmodule : arl_panel_model

// ===== tb/tb_arl_top.sv
// Bench for the alarm-to-relay block: relay table, delays, latching,
// flashing, interrupt, bus error and analog output.
// Assumes arl_pkg, arl_top and arl_panel_model are compiled first.
`timescale 1ns/1ns
module tb_arl_top;
  localparam int TK  = 4;
  localparam int PER = arl_pkg::FL_PER * TK;
  typedef struct packed {
    logic [3:0]  cfg;
    logic [15:0] val;
    logic [1:0]  coil;
  } arl_row_s;
  // Relay config, display value, expected coils of relays 1 and 0
  localparam arl_row_s ROWS [9] = '{
    '{4'h0, 16'h0032, 2'b00}, '{4'h0, 16'h0046, 2'b10}, '{4'h0, 16'h0096, 2'b11},
    '{4'h0, 16'h0063, 2'b10}, '{4'h0, 16'h0064, 2'b11}, '{4'h2, 16'h0096, 2'b10},
    '{4'h2, 16'h00C8, 2'b11}, '{4'h4, 16'h0032, 2'b01}, '{4'h4, 16'h00C8, 2'b10}};
  localparam logic [15:0] SP [3] = '{16'h0064, 16'h00C8, 16'h003C};
  localparam logic [7:0]  AL [3] = '{8'h01, 8'h01, 8'h02};
  logic        mclk = 1'b0, rst = 1'b1;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0]  strb = 4'hF;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp, rng, rr;
  logic [15:0] dval = 16'h0, aout;
  logic [7:0]  coil, led;
  logic [2:0]  press = 3'b000, pins;
  int          errors = 0;
  int          checks = 0;

  // Clock at 20 MHz
  always #25 mclk = ~mclk;

  arl_top #(.TICK_CYC(TK)) dut (
    .mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .display_value(dval), .ack_btn(pins[0]), .aux_btn(pins[1]), .remote_in(pins[2]),
    .relay_coil(coil), .annunciator_led(led), .irq(irq), .aout_code(aout),
    .analog_range_select(rng));

  arl_panel_model panel (.mclk(mclk), .press(press), .pins(pins));

  task automatic finish_test();
    $display("Checks %0d, errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  // Bounded wait on awready, bvalid, arready or rvalid, sampled at the edge
  task automatic waitfor(input int s);
    int   n;
    logic v;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      v = (s == 0) ? (awready && wready) : (s == 1) ? bvalid : (s == 2) ? arready : rvalid;
    end while (v !== 1'b1 && n < 40);
    // A wait that runs out counts as a mismatch
    chk(v, 1'b1);
  endtask : waitfor

  // Leading edge keeps a ready release and the next raise apart
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    waitfor(0);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    waitfor(1);
    bready <= 1'b0;
    rr = bresp;
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    waitfor(2);
    arvalid <= 1'b0;
    waitfor(3);
    rready <= 1'b0;
    rd = rdata;
    rr = rresp;
  endtask : rdr

  task automatic push(input int b);
    press[b] <= 1'b1;
    @(posedge mclk);
    press[b] <= 1'b0;
    cyc(12);
  endtask : push

  // Lit cycles of relay 0 over one full flash period, any phase
  task automatic led_on(input int exp);
    int n;
    n = 0;
    repeat (PER) begin
      @(posedge mclk);
      n += (led[0] === 1'b1);
    end
    chk(n, exp);
  endtask : led_on

  // Main sequence
  initial begin
    cyc(12);
    rst <= 1'b0;
    cyc(2);
    chk(coil, 8'h00);
    rdr(arl_pkg::A_AHI);
    chk(rd, 32'h3E8);
    rdr(8'h80);
    chk(rd, 32'h0);
    rdr(8'h18);
    chk(rr, arl_pkg::RESP_ERR);
    chk(rd, 32'h0);
    strb <= 4'h1;
    wr(arl_pkg::A_AHI, 32'hFFFF_FFFF);
    chk(rr, arl_pkg::RESP_OK);
    strb <= 4'hF;
    wr(8'h20, 32'h1);
    chk(rr, arl_pkg::RESP_ERR);
    rdr(arl_pkg::A_AHI);
    chk(rd, 32'h3FF);
    // Three high alarms, no hysteresis; alarms 0 and 1 on relay 0
    for (int i = 0; i < 3; i++) begin
      wr(8'hC0 + 8'(4 * i), 32'h1);
      wr(8'hA0 + 8'(4 * i), {SP[i], 16'h0});
      wr(8'h80 + 8'(4 * i), {24'h0, AL[i]});
    end
    for (int i = 0; i < 9; i++) begin
      wr(8'h40, {28'h0, ROWS[i].cfg});
      dval <= ROWS[i].val;
      cyc(5);
      chk(coil[1:0], ROWS[i].coil);
    end
    // Trip delay of 4 ticks, broken once by a one-cycle dropout
    wr(8'h40, 32'h0);
    wr(8'hE0, 32'h4);
    dval <= 16'h0032;
    cyc(5);
    dval <= 16'h0096;
    cyc(8);
    chk(coil[0], 1'b0);
    dval <= 16'h0032;
    cyc(1);
    dval <= 16'h0096;
    cyc(10);
    chk(coil[0], 1'b0);
    cyc(12);
    chk(coil[0], 1'b1);
    wr(8'hE0, 32'h0);
    dval <= 16'h0032;
    // Latch, clear unacknowledged, then ack from the front button
    wr(8'h40, 32'h1);
    dval <= 16'h0096;
    cyc(8);
    led_on(arl_pkg::FL_FAST * TK);
    dval <= 16'h0032;
    cyc(8);
    chk(coil[0], 1'b1);
    led_on(arl_pkg::FL_SLOW * TK);
    push(0);
    chk(coil[0], 1'b0);
    // Early ack over the aux button, steady lamp, release on clear
    wr(arl_pkg::A_CTRL, 32'h2);
    wr(8'h40, 32'h9);
    dval <= 16'h0096;
    cyc(8);
    push(1);
    led_on(PER);
    chk(coil[0], 1'b1);
    dval <= 16'h0032;
    cyc(8);
    chk(coil[0], 1'b0);
    // Ack during alarm without early ack is lost; remote ack releases
    wr(arl_pkg::A_CTRL, 32'h4);
    wr(8'h40, 32'h1);
    dval <= 16'h0096;
    cyc(8);
    push(0);
    dval <= 16'h0032;
    cyc(8);
    chk(coil[0], 1'b1);
    push(2);
    chk(coil[0], 1'b0);
    // Fixed pairing under PI control, no allocation on alarm 0
    wr(8'h40, 32'h0);
    wr(8'h80, 32'h0);
    wr(arl_pkg::A_CTRL, 32'h1);
    dval <= 16'h0096;
    cyc(6);
    chk(coil[0], 1'b1);
    wr(arl_pkg::A_CTRL, 32'h0);
    cyc(6);
    chk(coil[0], 1'b0);
    // Interrupt: unmasked relay 0 raises it, read clears, relay 1 masked
    rdr(arl_pkg::A_IST);
    wr(arl_pkg::A_IMSK, 32'h1);
    chk(irq, 1'b0);
    wr(8'h80, 32'h1);
    cyc(4);
    chk(irq, 1'b1);
    rdr(arl_pkg::A_IST);
    chk(rd[0], 1'b1);
    cyc(2);
    chk(irq, 1'b0);
    dval <= 16'h0032;
    cyc(5);
    dval <= 16'h0046;
    cyc(5);
    chk({irq, coil[1]}, 2'b01);
    // Analog range and end points; range code 3 falls back to 4-20mA
    wr(arl_pkg::A_CTRL, 32'h20);
    cyc(1);
    chk(rng, 2'b10);
    wr(arl_pkg::A_CTRL, 32'h30);
    cyc(1);
    chk(rng, 2'b00);
    dval <= 16'hFFFF;
    cyc(4);
    chk(aout, 16'hFFFF);
    dval <= 16'h0000;
    cyc(4);
    chk(aout, 16'h0000);
    // A third of the 0..0x3FF span gives a third of full scale
    dval <= 16'h0155;
    cyc(4);
    chk(aout, 16'h5555);
    // Low alarm on alarm 2 trips at its setpoint and not above
    wr(8'hA8, 32'h0000_003C);
    wr(8'hC8, 32'h2);
    dval <= 16'h003C;
    cyc(4);
    chk(coil[1], 1'b1);
    dval <= 16'h003D;
    cyc(4);
    chk(coil[1], 1'b0);
    // Mid-run reset drops a held latch, as power loss would
    wr(8'h40, 32'h1);
    dval <= 16'h0096;
    cyc(8);
    chk(coil[0], 1'b1);
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(2);
    chk(coil, 8'h00);
    chk(led, 8'h00);
    finish_test();
  end

  // Watchdog, far beyond the several hundred cycles the run needs
  initial begin
    cyc(20000);
    errors++;
    finish_test();
  end
endmodule : tb_arl_top
